// >>> include/tcc_pkg.sv
package tcc_pkg;

  // ****************************************************************
  // Register map and field layout
  // ****************************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFS_CONTROL  = 8'h00;
  localparam logic [7:0]  OFS_RELOAD   = 8'h04;
  localparam logic [7:0]  OFS_PRESCALE = 8'h08;
  localparam logic [7:0]  OFS_COUNT    = 8'h0C;
  localparam logic [7:0]  OFS_EVENT    = 8'h10;
  localparam int          POS_UPDATE_GEN = 0;
  localparam logic [1:0]  ALIGN_EDGE   = 2'h0;
  localparam logic [1:0]  ALIGN_DOWN   = 2'h1;
  localparam logic [1:0]  ALIGN_UP     = 2'h2;
  localparam logic [1:0]  ALIGN_BOTH   = 2'h3;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]  RST_CONTROL  = 8'h00;
  localparam logic [15:0] RST_RELOAD   = 16'hFFFF;
  localparam logic [15:0] RST_PRESCALE = 16'h0000;
  localparam logic [15:0] RST_COUNT    = 16'h0000;

  // Control register one, bit 7 down to bit 0
  typedef struct packed {
    logic       reload_buffer_enable;
    logic [1:0] alignment_mode_select;
    logic       count_direction;
    logic       single_pulse_mode;
    logic       update_request_source;
    logic       update_disable;
    logic       counter_enable_bit;
  } tcc_cr1_t;

  // Slave controller requests, same clock domain
  typedef struct packed {
    logic reset_req;
    logic trigger_mode;
  } tcc_slave_t;

endpackage : tcc_pkg

// >>> hdl/tcc_sync.sv
`timescale 1ns/1ns
`default_nettype none

// Three-stage input synchroniser with agreement filter
module tcc_sync
  import tcc_pkg::*;
(
  input  wire logic clock_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      level_o
);

  logic s1_r, s2_r, s3_r, level_r;
  logic s1_nxt, s2_nxt, s3_nxt, level_nxt;

  // Only stage two looks at stage one; level moves once two and three agree
  always_comb
  begin
    s1_nxt    = async_i;
    s2_nxt    = s1_r;
    s3_nxt    = s2_r;
    level_nxt = (s2_r == s3_r) ? s3_r : level_r;
  end

  // State registers
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end
    else
    begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      s3_r    <= s3_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_o = level_r;

endmodule : tcc_sync

`default_nettype wire

// >>> hdl/tcc_shadow.sv
`timescale 1ns/1ns
`default_nettype none

// Buffer-to-active copy, loaded on update events or bypassed
module tcc_shadow
  import tcc_pkg::*;
#(
  parameter int           W         = 16,
  parameter logic [W-1:0] RESET_VAL = '0
)
(
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] buffer_i,
  input  wire logic         bypass_i,
  input  wire logic         load_i,
  output logic      [W-1:0] value_o
);

  logic [W-1:0] shadow_r;
  logic [W-1:0] shadow_nxt;

  // Copy only on load so the active value never changes mid-period while buffered
  always_comb
  begin
    shadow_nxt = load_i ? buffer_i : shadow_r;
  end

  // Shadow register
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      shadow_r <= RESET_VAL;
    else
      shadow_r <= shadow_nxt;
  end

  // Unbuffered use sees the written value at once
  assign value_o = bypass_i ? buffer_i : shadow_r;

endmodule : tcc_shadow

`default_nettype wire

// >>> hdl/tcc_top.sv
// Functional notes
// R1 - Reload buffer bit selects direct or shadowed reload
// R2 - Alignment 00 counts one way per direction
// R3 - Alignment 01 up/down, compare flags counting down
// R4 - Alignment 10 up/down, compare flags counting up
// R5 - Alignment 11 up/down, compare flags both ways
// R6 - Software keeps alignment while counter enabled
// R7 - Direction 0 counts up, 1 down
// R8 - Single pulse stops counter, clears enable
// R9 - Source 0: request on any update cause
// R10 - Source 1: request only on over/underflow
// R11 - Updates enabled: events load shadow registers
// R12 - Updates disabled: no event, shadows hold
// R13 - Generation bit or slave reset still reinitialise
// R14 - Enable bit 0 stops, 1 runs
// R15 - Software enables before external/gated/encoder modes
// R16 - Trigger mode sets enable in hardware
// R17 - Buffered reload moves to shadow on update
`timescale 1ns/1ns
`default_nettype none

module tcc_top
  import tcc_pkg::*;
#(
  parameter int CW = 16
)
(
  input  wire logic                       clock_i,
  input  wire logic                       reset_n_i,
  input  wire logic [tcc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [31:0]                wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [31:0]                rdata_o,
  input  wire tcc_pkg::tcc_slave_t        slave_i,
  input  wire logic                       trigger_pin_i,
  output logic      [CW-1:0]              count_o,
  output logic                            counting_down_o,
  output logic                            compare_flag_allow_o,
  output logic                            update_event_o,
  output logic                            update_irq_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tcc_cr1_t      cr1_r, cr1_nxt;
  logic [CW-1:0] reload_buf_r, reload_buf_nxt;
  logic [CW-1:0] presc_buf_r, presc_buf_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] psc_cnt_r, psc_cnt_nxt;
  logic          cdown_r, cdown_nxt;
  logic          trig_prev_r, trig_prev_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic          uev_r, uev_nxt;
  logic          irq_r, irq_nxt;
  logic          cmp_r, cmp_nxt;

  logic [CW-1:0] reload_act;
  logic [CW-1:0] presc_act;
  logic          trig_level;
  logic          trig_rise;
  logic          wr_ctl, wr_reload, wr_presc, wr_cnt, sw_gen;
  logic          reinit;
  logic          tick;
  logic          wrap;
  logic          update_event;
  logic          center;
  logic          going_down;

  // ****************************************************************
  // Submodules
  // ****************************************************************

  // Trigger arrives from a pin, so it is synchronised first
  tcc_sync u_trig_sync (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .async_i   (trigger_pin_i),
    .level_o   (trig_level)
  );

  // Reload shadow; bypassed while buffering is off
  tcc_shadow #(
    .W         (CW),
    .RESET_VAL (RST_RELOAD[CW-1:0])
  ) u_reload (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .buffer_i  (reload_buf_r),
    .bypass_i  (!cr1_r.reload_buffer_enable), // [R1]
    .load_i    (update_event),                         // [R17] [R11]
    .value_o   (reload_act)
  );

  // Prescaler is always buffered
  tcc_shadow #(
    .W         (CW),
    .RESET_VAL (RST_PRESCALE[CW-1:0])
  ) u_presc (
    .clock_i   (clock_i),
    .reset_n_i (reset_n_i),
    .buffer_i  (presc_buf_r),
    .bypass_i  (1'b0),
    .load_i    (update_event),                         // [R12]
    .value_o   (presc_act)
  );

  // ****************************************************************
  // Event decode
  // ****************************************************************

  // Bus strobes and update causes
  always_comb
  begin
    wr_ctl    = wr_i && (addr_i == OFS_CONTROL);
    wr_reload = wr_i && (addr_i == OFS_RELOAD);
    wr_presc  = wr_i && (addr_i == OFS_PRESCALE);
    wr_cnt    = wr_i && (addr_i == OFS_COUNT);
    sw_gen    = wr_i && (addr_i == OFS_EVENT) && wdata_i[POS_UPDATE_GEN];
    trig_rise = trig_level && !trig_prev_r;
    reinit    = sw_gen || slave_i.reset_req;                 // [R13]
    center    = (cr1_r.alignment_mode_select != ALIGN_EDGE);
    going_down = center ? cdown_r : cr1_r.count_direction;  // [R7]
    tick      = cr1_r.counter_enable_bit && (psc_cnt_r == presc_act); // [R14]
    if (going_down)
      wrap = tick && (cnt_r == '0);
    else
      wrap = tick && (cnt_r >= reload_act);
    // Disabled updates suppress the event but not the reinit
    update_event = !cr1_r.update_disable && (wrap || reinit);         // [R11] [R12]
  end

  // ****************************************************************
  // Counter and prescaler
  // ****************************************************************

  // Reinit has priority over software writes and counting
  always_comb
  begin
    cnt_nxt     = cnt_r;
    cdown_nxt   = cdown_r;
    psc_cnt_nxt = psc_cnt_r;
    if (reinit)
    begin
      psc_cnt_nxt = '0;                                      // [R13]
      cdown_nxt   = 1'b0;
      cnt_nxt     = (!center && cr1_r.count_direction) ? reload_act : '0;
    end
    else
    begin
      if (cr1_r.counter_enable_bit)                          // [R14]
        psc_cnt_nxt = tick ? '0 : psc_cnt_r + 1'b1;
      if (wr_cnt)
        cnt_nxt = wdata_i[CW-1:0];
      else if (tick)
      begin
        if (!center)
        begin
          // Edge-aligned: single direction, wrap to the far end
          if (cr1_r.count_direction)                         // [R2] [R7]
            cnt_nxt = wrap ? reload_act : cnt_r - 1'b1;
          else
            cnt_nxt = wrap ? '0 : cnt_r + 1'b1;
        end
        else if (reload_act == '0)
          cnt_nxt = '0;                    // Nothing to swing over
        else if (cdown_r)
        begin
          // Center-aligned: turn round at zero and at reload
          cnt_nxt   = wrap ? {{(CW-1){1'b0}}, 1'b1} : cnt_r - 1'b1; // [R3] [R4] [R5]
          cdown_nxt = !wrap;
        end
        else
        begin
          cnt_nxt   = wrap ? reload_act - 1'b1 : cnt_r + 1'b1;
          cdown_nxt = wrap;
        end
      end
    end
  end

  // ****************************************************************
  // Register file writes
  // ****************************************************************

  // Hardware set of the enable wins over any clear in the same cycle
  always_comb
  begin
    cr1_nxt        = cr1_r;
    reload_buf_nxt = reload_buf_r;
    presc_buf_nxt  = presc_buf_r;
    trig_prev_nxt  = trig_level;
    if (wr_ctl)
      cr1_nxt = tcc_cr1_t'(wdata_i[7:0]);   // Alignment change is on software
    if (wr_reload)
      reload_buf_nxt = wdata_i[CW-1:0];
    if (wr_presc)
      presc_buf_nxt = wdata_i[CW-1:0];
    if (cr1_r.single_pulse_mode && update_event)
      cr1_nxt.counter_enable_bit = 1'b0;                     // [R8]
    if (slave_i.trigger_mode && trig_rise)
      cr1_nxt.counter_enable_bit = 1'b1;                     // [R16]
  end

  // ****************************************************************
  // Outputs and read path
  // ****************************************************************

  // Read data only in the cycle after the strobe
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd_i)
    begin
      case (addr_i)
        OFS_CONTROL:
          rdata_nxt = {24'h00_0000, cr1_r.reload_buffer_enable,
                       cr1_r.alignment_mode_select, going_down,
                       cr1_r.single_pulse_mode, cr1_r.update_request_source,
                       cr1_r.update_disable, cr1_r.counter_enable_bit};
        OFS_RELOAD:   rdata_nxt = 32'(reload_buf_r);
        OFS_PRESCALE: rdata_nxt = 32'(presc_buf_r);
        OFS_COUNT:    rdata_nxt = 32'(cnt_r);
        default:      rdata_nxt = 32'h0000_0000;
      endcase
    end
    uev_nxt = update_event;
    // Request source filters software and slave causes
    irq_nxt = update_event && (!cr1_r.update_request_source || wrap); // [R9] [R10]
    case (cr1_nxt.alignment_mode_select)
      ALIGN_DOWN: cmp_nxt = cdown_nxt;                       // [R3]
      ALIGN_UP:   cmp_nxt = !cdown_nxt;                      // [R4]
      ALIGN_BOTH: cmp_nxt = 1'b1;                            // [R5]
      default:    cmp_nxt = 1'b1;                            // [R2]
    endcase
  end

  // State registers
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
    begin
      cr1_r        <= tcc_cr1_t'(RST_CONTROL);
      reload_buf_r <= RST_RELOAD[CW-1:0];
      presc_buf_r  <= RST_PRESCALE[CW-1:0];
      cnt_r        <= RST_COUNT[CW-1:0];
      psc_cnt_r    <= RST_PRESCALE[CW-1:0];
      cdown_r      <= 1'b0;
      trig_prev_r  <= 1'b0;
      rdata_r      <= 32'h0000_0000;
      uev_r        <= 1'b0;
      irq_r        <= 1'b0;
      cmp_r        <= 1'b1;
    end
    else
    begin
      cr1_r        <= cr1_nxt;
      reload_buf_r <= reload_buf_nxt;
      presc_buf_r  <= presc_buf_nxt;
      cnt_r        <= cnt_nxt;
      psc_cnt_r    <= psc_cnt_nxt;
      cdown_r      <= cdown_nxt;
      trig_prev_r  <= trig_prev_nxt;
      rdata_r      <= rdata_nxt;
      uev_r        <= uev_nxt;
      irq_r        <= irq_nxt;
      cmp_r        <= cmp_nxt;
    end
  end

  assign rdata_o              = rdata_r;
  assign count_o              = cnt_r;
  assign counting_down_o      = cdown_r;
  assign compare_flag_allow_o = cmp_r;
  assign update_event_o       = uev_r;
  assign update_irq_o         = irq_r;

endmodule : tcc_top

`default_nettype wire

// >>> bench/tcc_top_checker.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Port checker for the timer control block
// ****
module tcc_top_checker
  import tcc_pkg::*;
#(
  parameter int CW = 16
)
(
  input wire logic                       clock_i,
  input wire logic                       reset_n_i,
  input wire logic [tcc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0]                wdata_i,
  input wire logic                       wr_i,
  input wire tcc_pkg::tcc_slave_t        slave_i,
  input wire logic [CW-1:0]              count_o,
  input wire logic                       counting_down_o,
  input wire logic                       compare_flag_allow_o,
  input wire logic                       update_event_o,
  input wire logic                       update_irq_o
);
  tcc_cr1_t   c_r;
  tcc_cr1_t   c_nxt;
  logic       reinit;
  logic       eu;
  logic [1:0] am;

  // Software copy of control; enable bit unused, hardware moves it
  always_comb
  begin
    c_nxt = c_r;
    if (wr_i && addr_i == OFS_CONTROL)
      c_nxt = tcc_cr1_t'(wdata_i[7:0]);
  end
  always_ff @(posedge clock_i)
  begin
    if (!reset_n_i)
      c_r <= tcc_cr1_t'(RST_CONTROL);
    else
      c_r <= c_nxt;
  end

  // Generation write or slave reset both restart the counter
  assign reinit = (wr_i && addr_i == OFS_EVENT && wdata_i[POS_UPDATE_GEN]) || slave_i.reset_req;
  assign am     = c_r.alignment_mode_select;
  assign eu     = am == ALIGN_EDGE && !c_r.count_direction;

  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);

  a_reinit_event: assert property (
    reinit && !c_r.update_disable |=> update_event_o)
    else $error("update event missing after restart");
  a_source_filter: assert property (
    reinit && !c_r.update_disable |=> update_irq_o != $past(c_r.update_request_source))
    else $error("update request filter wrong");
  a_disabled_quiet: assert property (
    c_r.update_disable && $past(c_r.update_disable) && $past(c_r.update_disable, 2)
    |-> !update_event_o && !update_irq_o)
    else $error("update seen while disabled");
  a_reinit_zero: assert property (
    reinit && eu |=> count_o == '0)
    else $error("counter not restarted");
  a_irq_needs_event: assert property (
    update_irq_o |-> update_event_o)
    else $error("request without update event");
  a_edge_allow: assert property (
    $stable(c_r) && am == ALIGN_EDGE |-> compare_flag_allow_o)
    else $error("compare blocked in edge mode");
  a_center_allow: assert property (
    $stable(c_r) && am != ALIGN_EDGE |-> compare_flag_allow_o ==
    (am == ALIGN_BOTH || counting_down_o == (am == ALIGN_DOWN)))
    else $error("compare qualifier wrong in center mode");
  a_up_step: assert property (
    $stable(c_r) && eu && !$past(wr_i) && $changed(count_o)
    |-> count_o == $past(count_o) + 1'b1 || count_o == '0)
    else $error("up count step wrong");
  a_pulse_stop: assert property (
    c_r.single_pulse_mode && update_event_o |-> ##3 $stable(count_o) [*4])
    else $error("counter runs after single pulse");
endmodule : tcc_top_checker

bind tcc_top tcc_top_checker #(.CW(CW)) i_tcc_top_checker (
  .clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .slave_i, .count_o,
  .counting_down_o, .compare_flag_allow_o, .update_event_o, .update_irq_o
);
`default_nettype wire

// >>> bench/tcc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Timer control bench with a counting model
// ****
module tcc_top_tb;
  import tcc_pkg::*;
  logic        clock_i       = 1'b0;
  logic        reset_n_i     = 1'b0;
  logic [7:0]  addr_i        = '0;
  logic [31:0] wdata_i       = '0;
  logic        wr_i          = 1'b0;
  logic        rd_i          = 1'b0;
  tcc_slave_t  slave_i       = '0;
  logic        trigger_pin_i = 1'b0;
  logic [31:0] rdata_o;
  logic [15:0] count_o;
  logic        counting_down_o;
  logic        update_event_o;
  logic        update_irq_o;
  logic        compare_flag_allow_o;
  logic [15:0] c0;
  int          failures    = 0;
  int          comparisons = 0;
  int          ev, iq, mx, r, p, per, dn, up, dw, fa;

  tcc_top i_tcc_top (
    .clock_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .slave_i,
    .trigger_pin_i, .count_o, .counting_down_o, .compare_flag_allow_o,
    .update_event_o, .update_irq_o
  );

  always #5 clock_i = ~clock_i;

  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task test_done;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  task wr(input logic [7:0] a, input int v);
    @(posedge clock_i);
    addr_i  <= a;
    wdata_i <= v;
    wr_i    <= 1'b1;
    @(posedge clock_i);
    wr_i    <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task rd(input logic [7:0] a, input int e);
    @(posedge clock_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clock_i);
    rd_i   <= 1'b0;
    #1;
    chk("rdata", rdata_o, e);
  endtask : rd

  // Edge model: every change is one step, wrapping at the reload
  task run(input int n, input int rl);
    int q;
    #1;
    q = count_o;
    repeat (n)
    begin
      @(posedge clock_i);
      #1;
      ev += update_event_o;
      iq += update_irq_o;
      mx = (count_o > mx) ? count_o : mx;
      if (count_o !== q)
        chk("step", count_o, dn ? (q == 0 ? rl : q - 1) : (q == rl ? 0 : q + 1));
      q = count_o;
    end
  endtask : run

  initial
  begin
    void'($urandom(32'hFC991A7C));
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    rd(OFS_CONTROL, 0);
    rd(OFS_RELOAD, 16'hFFFF);
    rd(OFS_COUNT, 0);
    rd(8'h20, 0);
    r = $urandom_range(16'hFFFF);
    wr(OFS_RELOAD, r);
    rd(OFS_RELOAD, r);
    wr(OFS_CONTROL, 8'hE6);
    rd(OFS_CONTROL, 8'hE6);
    // Up and down, with and without update disable and source filter
    for (int t = 0; t < 4; t++)
    begin
      r   = 2 + $urandom_range(3);
      p   = $urandom_range(2);
      per = (r + 1) * (p + 1);
      dn  = t[1];
      wr(OFS_CONTROL, dn << 4);
      wr(OFS_RELOAD, r);
      wr(OFS_PRESCALE, p);
      wr(OFS_EVENT, 1);
      rd(OFS_COUNT, dn ? r : 0);
      wr(OFS_CONTROL, {t[1], 1'b0, t[1], t[0], 1'b1}); // Software enables first
      run(2 * per, r);
      ev = 0;
      iq = 0;
      run(3 * per, r);
      chk("events", ev, t[0] ? 0 : 3);
      chk("requests", iq, t[0] ? 0 : 3);
    end
    dn = 0;
    wr(OFS_CONTROL, 0);
    wr(OFS_EVENT, 1);
    ev = 0;
    wr(OFS_CONTROL, 8'h09);
    run(3 * per, r);
    chk("one_shot", ev, 1);
    rd(OFS_CONTROL, 8'h08);
    // Shadowed reload holds while updates are off, direct one acts at once
    // Single pulse off first; with it on, the restart event would only clear an enable that is already 0
    wr(OFS_CONTROL, 0);
    wr(OFS_PRESCALE, 0);
    wr(OFS_RELOAD, 3);
    wr(OFS_EVENT, 1);
    wr(OFS_CONTROL, 8'h83);
    wr(OFS_RELOAD, 9);
    mx = 0;
    run(20, 3);
    chk("buffered", mx, 3);
    wr(OFS_CONTROL, 8'h03);
    run(20, 9);
    chk("direct", mx, 9);
    // Enable stays off while leaving edge mode
    for (int m = 1; m < 4; m++)
    begin
      wr(OFS_CONTROL, 0);
      wr(OFS_RELOAD, 4);
      wr(OFS_EVENT, 1);
      wr(OFS_CONTROL, (m << 5) | 1);
      up = 0;
      dw = 0;
      fa = 0;
      mx = 0;
      repeat (20)
      begin
        @(posedge clock_i);
        #1;
        dw += counting_down_o;
        fa += (compare_flag_allow_o !== (m == 3 || counting_down_o == (m == 1)));
        up += !counting_down_o;
        mx = (count_o > mx) ? count_o : mx;
      end
      chk("turns", dw > 0 && up > 0 && mx == 4, 1);
      chk("allow", fa, 0);
    end
    for (int u = 0; u < 2; u++)
    begin
      wr(OFS_CONTROL, u << 2);
      @(posedge clock_i);
      slave_i.reset_req <= 1'b1;
      @(posedge clock_i);
      slave_i.reset_req <= 1'b0;
      #1;
      chk("slave_event", update_event_o, 1);
      chk("slave_request", update_irq_o, 1 - u);
    end
    wr(OFS_CONTROL, 0);
    slave_i.trigger_mode <= 1'b1;
    trigger_pin_i        <= 1'b1;
    c0 = count_o;
    // Look just after the edge so the counter has settled
    for (int k = 0; k < 20 && count_o === c0; k++)
    begin
      @(posedge clock_i);
      #1;
    end
    chk("trigger_start", count_o !== c0, 1);
    // A start that never came is already counted; skip the read then
    if (count_o !== c0)
      rd(OFS_CONTROL, 1);
    test_done();
  end
endmodule : tcc_top_tb
`default_nettype wire
